// file: pkg/hrx_pkg.sv
package hrx_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] OFS_RX_SEL  = 12'h400;
  localparam logic [11:0] OFS_RX_DEF  = 12'h404;
  localparam logic [11:0] OFS_MAX_LEN = 12'h410;
  localparam logic [11:0] OFS_TX_SEL  = 12'h480;
  localparam int          SEL_DIR_BIT  = 14;
  localparam int          SEL_BUSY_BIT = 15;
  localparam logic [15:0] RST_SEL      = 16'h0000;
  localparam logic [15:0] RST_DEF      = 16'h0000;
  localparam logic [15:0] RST_MAX_LEN  = 16'h0000;
  // ----------------------------------------
  // framing constants
  // ----------------------------------------
  localparam int          CHANNELS    = 256;
  localparam int          FIFO_DEPTH  = 32;
  localparam logic [15:0] MIN_LEN_NONE = 16'h0001;
  localparam logic [15:0] MIN_LEN_C16  = 16'h0004;
  localparam logic [15:0] MIN_LEN_C32  = 16'h0006;
  localparam logic [2:0]  FCS_LEN_C16  = 3'h2;
  localparam logic [2:0]  FCS_LEN_C32  = 3'h4;
  localparam logic [15:0] HOLD_DEPTH   = 16'h0006;
  localparam logic [2:0]  STUFF_ONES   = 3'h5;
  localparam logic [2:0]  ABORT_ONES   = 3'h7;
  localparam logic [7:0]  FLAG_BYTE    = 8'h7E;
  localparam logic [31:0] POLY16 = 32'h0000_8408;
  localparam logic [31:0] POLY32 = 32'hEDB8_8320;
  localparam logic [31:0] INIT16 = 32'h0000_FFFF;
  localparam logic [31:0] INIT32 = 32'hFFFF_FFFF;
  localparam logic [31:0] GOOD16 = 32'h0000_F0B8;
  localparam logic [31:0] GOOD32 = 32'hDEBB_20E3;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    CRC_NONE = 2'h0, CRC_16 = 2'h1, CRC_32 = 2'h2, CRC_BAD = 2'h3
  } hrx_crc_t;
  typedef struct packed {
    logic     rx_destuff_off;
    logic     rx_abort_ignore;
    logic     rx_fcs_strip;
    logic     rx_bit_order;
    logic     rx_invert;
    hrx_crc_t crc_sel;
    logic     rx_length_check_en;
    logic     rx_transparent;
  } hrx_cfg_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } hrx_bus_req_t;
  typedef struct packed {
    logic       valid;
    logic       data;
    logic [7:0] chan;
  } hrx_bit_t;
  typedef struct packed {
    logic       abort;
    logic       eop;
    logic [7:0] data;
  } hrx_word_t;
  typedef enum logic [3:0] {
    ST_HUNT  = 4'b0001,
    ST_FRAME = 4'b0010,
    ST_DROP  = 4'b0100,
    ST_FLUSH = 4'b1000
  } hrx_state_t;
endpackage

// file: rtl/hrx_channel.sv
`timescale 1ns/1ps

// ----------------------------------------
// output buffer
// ----------------------------------------
module hrx_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          ov;
    logic [W-1:0]  od;
  } hrx_fifo_st_t;
  hrx_fifo_st_t st_reg, st_next;
  logic [W-1:0] mem [DEPTH];
  logic         push, pop;

  assign in_ready  = st_reg.cnt != (AW+1)'(DEPTH);
  assign push      = in_valid & in_ready;
  assign pop       = (st_reg.cnt != '0) & (~st_reg.ov | out_ready);
  assign out_valid = st_reg.ov;
  assign out_data  = st_reg.od;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
      st_next.ov = 1'b1;
      st_next.od = mem[st_reg.rp];
    end else if (out_ready) begin
      st_next.ov = 1'b0;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wp] <= in_data;
    end
  end
endmodule

// ----------------------------------------
// receive channel configuration and engine
// ----------------------------------------
module hrx_channel (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // register port
  input  hrx_pkg::hrx_bus_req_t bus,
  output logic [15:0]        rdata,
  // serial receive stream
  input  hrx_pkg::hrx_bit_t  rx_in,
  output logic               rx_bit_ready,
  // packet data out
  output logic               fifo_valid,
  output hrx_pkg::hrx_word_t fifo_word,
  input  wire logic          fifo_ready
);
  import hrx_pkg::*;

  typedef struct packed {
    logic [7:0]      sel_chan;
    logic            sel_dir;
    logic            busy;
    logic [7:0]      tx_chan;
    logic            tx_dir;
    logic            tx_busy;
    hrx_cfg_t        def;
    logic [15:0]     max_len;
    logic [15:0]     rdata;
    logic            ready;
    hrx_state_t      state;
    logic [7:0]      win;
    logic [2:0]      ones;
    logic [2:0]      bitcnt;
    logic [7:0]      asm_byte;
    logic [15:0]     count;
    logic [31:0]     crc;
    logic [5:0][7:0] hold;
    logic            emitted;
    logic [2:0]      fidx;
    logic [2:0]      fend;
    logic            out_valid;
    hrx_word_t       out;
  } hrx_st_t;

  hrx_st_t     st, nx;
  hrx_cfg_t    ram [CHANNELS];
  hrx_cfg_t    cfg;
  logic        acc, rbit, flag_hit, abort_hit, stuff, byte_done;
  logic        w32, crc_ok, in_ready;
  logic [7:0]  win_n, asm_n;
  logic [2:0]  ones_n, strip_n;
  logic [15:0] cnt_n, min_len, held;
  logic [31:0] crc_n;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] crc_upd(input logic [31:0] c,
                                          input logic [7:0]  d,
                                          input logic        wide);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[0] ^ d[i];
      r  = r >> 1;
      if (fb) begin
        r = r ^ (wide ? POLY32 : POLY16);
      end
    end
    return r;
  endfunction

  // bytes are built first-bit-low; flipping gives the other order
  function automatic logic [7:0] lane(input logic [7:0] b, input logic flip);
    logic [7:0] r;
    r = b;
    if (flip) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = b[7-i];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // per-bit decode
  // ----------------------------------------
  assign cfg       = ram[rx_in.chan];
  assign acc       = rx_in.valid & st.ready;
  assign rbit      = rx_in.data ^ cfg.rx_invert;
  assign win_n     = {rbit, st.win[7:1]};
  assign flag_hit  = win_n == FLAG_BYTE;
  assign ones_n    = !rbit ? 3'h0 : (st.ones == ABORT_ONES) ? st.ones : st.ones + 3'h1;
  assign abort_hit = (ones_n == ABORT_ONES) & ~cfg.rx_abort_ignore;
  assign stuff     = ~rbit & (st.ones == STUFF_ONES) & ~cfg.rx_destuff_off;
  assign asm_n     = {rbit, st.asm_byte[7:1]};
  assign byte_done = st.bitcnt == 3'h7;
  assign w32       = cfg.crc_sel == CRC_32;
  assign crc_n     = crc_upd(st.crc, asm_n, w32);
  assign cnt_n     = (st.count == 16'hFFFF) ? st.count : st.count + 16'h1;
  assign held      = (st.count >= HOLD_DEPTH) ? HOLD_DEPTH : st.count;

  always_comb begin
    unique case (cfg.crc_sel)
      CRC_16: begin
        min_len = MIN_LEN_C16;
        strip_n = cfg.rx_fcs_strip ? FCS_LEN_C16 : 3'h0;
        crc_ok  = st.crc == GOOD16;
      end
      CRC_32: begin
        min_len = MIN_LEN_C32;
        strip_n = cfg.rx_fcs_strip ? FCS_LEN_C32 : 3'h0;
        crc_ok  = st.crc == GOOD32;
      end
      // illegal code is treated as no verification
      default: begin
        min_len = MIN_LEN_NONE;
        strip_n = 3'h0;
        crc_ok  = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nx       = st;
    nx.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_RX_SEL:  nx.rdata = {st.busy, st.sel_dir, 6'h00, st.sel_chan};
        OFS_RX_DEF:  nx.rdata = {7'h00, st.def};
        OFS_MAX_LEN: nx.rdata = st.max_len;
        OFS_TX_SEL:  nx.rdata = {st.tx_busy, st.tx_dir, 6'h00, st.tx_chan};
        default:     nx.rdata = '0;
      endcase
    end
    // the access itself takes the cycle after the select write
    if (st.busy) begin
      nx.busy = 1'b0;
      if (st.sel_dir) begin
        nx.def = ram[st.sel_chan];
      end
    end
    nx.tx_busy = 1'b0;
    if (bus.wr) begin
      unique case (bus.addr)
        OFS_RX_SEL: begin
          if (!st.busy) begin
            nx.sel_chan = bus.wdata[7:0];
            nx.sel_dir  = bus.wdata[SEL_DIR_BIT];
            nx.busy     = 1'b1;
          end
        end
        OFS_RX_DEF:  nx.def     = hrx_cfg_t'(bus.wdata[8:0]);
        OFS_MAX_LEN: nx.max_len = bus.wdata;
        OFS_TX_SEL: begin
          if (!st.tx_busy) begin
            nx.tx_chan = bus.wdata[7:0];
            nx.tx_dir  = bus.wdata[SEL_DIR_BIT];
            nx.tx_busy = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (st.out_valid && in_ready) begin
      nx.out_valid = 1'b0;
    end
    unique case (st.state)
      ST_FLUSH: begin
        if (!nx.out_valid) begin
          nx.out_valid = 1'b1;
          nx.out.data  = lane(st.hold[st.fidx], cfg.rx_bit_order);
          nx.out.eop   = st.fidx == st.fend;
          nx.out.abort = 1'b0;
          nx.fidx      = st.fidx - 3'h1;
          if (st.fidx == st.fend) begin
            nx.state = ST_FRAME;
          end
        end
      end
      ST_HUNT, ST_FRAME, ST_DROP: begin
        if (acc) begin
          nx.win  = win_n;
          nx.ones = ones_n;
          if (cfg.rx_transparent) begin
            // raw octets, no delineation and no end of packet
            nx.state    = ST_HUNT;
            nx.bitcnt   = st.bitcnt + 3'h1;
            nx.asm_byte = asm_n;
            if (byte_done) begin
              nx.out_valid = 1'b1;
              nx.out.data  = lane(asm_n, cfg.rx_bit_order);
              nx.out.eop   = 1'b0;
              nx.out.abort = 1'b0;
            end
          end else if (flag_hit) begin
            nx.state = ST_FRAME;
            if (st.state == ST_FRAME && st.count != '0) begin
              // flag bits already sit in the partial byte
              if (byte_done && st.count >= min_len && crc_ok) begin
                nx.state = ST_FLUSH;
                nx.fidx  = 3'(held - 16'h1);
                nx.fend  = strip_n;
              end else if (st.emitted) begin
                nx.out_valid = 1'b1;
                nx.out       = '{abort: 1'b1, eop: 1'b1, data: 8'h00};
              end
            end
            nx.count   = '0;
            nx.bitcnt  = '0;
            nx.emitted = 1'b0;
            nx.crc     = w32 ? INIT32 : INIT16;
          end else if (abort_hit && st.state != ST_HUNT) begin
            nx.state = ST_HUNT;
            if (st.state == ST_FRAME && st.emitted) begin
              nx.out_valid = 1'b1;
              nx.out       = '{abort: 1'b1, eop: 1'b1, data: 8'h00};
            end
          end else if (st.state == ST_FRAME && !stuff) begin
            nx.bitcnt   = st.bitcnt + 3'h1;
            nx.asm_byte = asm_n;
            if (byte_done) begin
              nx.count = cnt_n;
              nx.crc   = crc_n;
              nx.hold  = {st.hold[4:0], asm_n};
              if (cfg.rx_length_check_en && cnt_n > st.max_len) begin
                // bytes already passed on are closed by a marker
                nx.state = ST_DROP;
                if (st.emitted) begin
                  nx.out_valid = 1'b1;
                  nx.out       = '{abort: 1'b1, eop: 1'b1, data: 8'h00};
                end
              end else if (st.count >= HOLD_DEPTH) begin
                // the last bytes wait so FCS and short packets can be held back
                nx.out_valid = 1'b1;
                nx.out.data  = lane(st.hold[5], cfg.rx_bit_order);
                nx.out.eop   = 1'b0;
                nx.out.abort = 1'b0;
                nx.emitted   = 1'b1;
              end
            end
          end
        end
      end
      default: nx.state = ST_HUNT;
    endcase
    // one byte per accepted bit at most, so a free slot is enough
    nx.ready = (nx.state != ST_FLUSH) && !nx.out_valid;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.sel_chan <= RST_SEL[7:0];
      st.tx_chan  <= RST_SEL[7:0];
      st.def      <= hrx_cfg_t'(RST_DEF[8:0]);
      st.max_len  <= RST_MAX_LEN;
      st.state    <= ST_HUNT;
    end else begin
      st <= nx;
    end
  end

  // definition RAM, cleared so unprogrammed channels run plain HDLC
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        ram[i] <= hrx_cfg_t'(RST_DEF[8:0]);
      end
    end else if (st.busy && !st.sel_dir) begin
      ram[st.sel_chan] <= st.def;
    end
  end

  hrx_fifo #(
    .W     ($bits(hrx_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (st.out_valid),
    .in_data   (st.out),
    .in_ready  (in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_word),
    .out_ready (fifo_ready)
  );

  assign rdata        = st.rdata;
  assign rx_bit_ready = st.ready;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_busy_span;
    @(posedge clk) disable iff (!rst_n)
    (bus.wr && bus.addr == OFS_RX_SEL && !st.busy) |=> st.busy ##1 !st.busy;
  endproperty
  a_busy_span: assert property (p_busy_span)
    else $error("busy not high for exactly one access cycle");

  property p_read_fetch;
    @(posedge clk) disable iff (!rst_n)
    (bus.wr && bus.addr == OFS_RX_SEL && !st.busy && bus.wdata[SEL_DIR_BIT])
      ##1 !(bus.wr && bus.addr == OFS_RX_DEF)
      |=> st.def == ram[st.sel_chan];
  endproperty
  a_read_fetch: assert property (p_read_fetch)
    else $error("indirect read did not fetch the entry");

  property p_write_store;
    @(posedge clk) disable iff (!rst_n)
    (bus.wr && bus.addr == OFS_RX_SEL && !st.busy && !bus.wdata[SEL_DIR_BIT])
      |=> ##1 ram[$past(bus.wdata[7:0], 2)] == $past(st.def);
  endproperty
  a_write_store: assert property (p_write_store)
    else $error("indirect write did not store the entry");

  property p_tx_layout;
    @(posedge clk) disable iff (!rst_n)
    (bus.wr && bus.addr == OFS_TX_SEL && !st.tx_busy)
      |=> st.tx_busy && st.tx_chan == $past(bus.wdata[7:0])
          && st.tx_dir == $past(bus.wdata[SEL_DIR_BIT]);
  endproperty
  a_tx_layout: assert property (p_tx_layout)
    else $error("transmit select layout wrong");

  property p_max_len;
    @(posedge clk) disable iff (!rst_n)
    (bus.wr && bus.addr == OFS_MAX_LEN) |=> st.max_len == $past(bus.wdata);
  endproperty
  a_max_len: assert property (p_max_len)
    else $error("maximum length not stored");

  property p_transparent;
    @(posedge clk) disable iff (!rst_n)
    (acc && cfg.rx_transparent && byte_done)
      |=> st.out_valid && !st.out.eop
          && st.out.data == lane($past(asm_n), $past(cfg.rx_bit_order));
  endproperty
  a_transparent: assert property (p_transparent)
    else $error("transparent byte wrong or marked as end");

  property p_overlength;
    @(posedge clk) disable iff (!rst_n)
    (acc && !cfg.rx_transparent && !flag_hit && !abort_hit && !stuff
      && st.state == ST_FRAME && byte_done && cfg.rx_length_check_en
      && cnt_n > st.max_len) |=> st.state == ST_DROP ##1 st.state != ST_FLUSH;
  endproperty
  a_overlength: assert property (p_overlength)
    else $error("over-length packet not dropped");

  property p_short_held;
    @(posedge clk) disable iff (!rst_n)
    (acc && !cfg.rx_transparent && flag_hit && st.state == ST_FRAME
      && st.count != '0 && st.count < min_len) |=> st.state == ST_FRAME;
  endproperty
  a_short_held: assert property (p_short_held)
    else $error("short packet was passed on");

  property p_abort;
    @(posedge clk) disable iff (!rst_n)
    (acc && !cfg.rx_transparent && !flag_hit && abort_hit
      && st.state == ST_FRAME) |=> st.state == ST_HUNT;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort sequence not honoured");

  property p_stall;
    @(posedge clk) disable iff (!rst_n)
    (st.out_valid || st.state == ST_FLUSH) |-> !rx_bit_ready;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stream accepted while output slot busy");
endmodule

// file: tb/hrx_src.sv
`timescale 1ns/1ps

// ----------------------------------------
// far side: serial bit source and buffer drain
// ----------------------------------------
module hrx_src (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // serial stream
  output hrx_pkg::hrx_bit_t  rx_in,
  input  wire logic          rx_bit_ready,
  // buffer drain
  input  wire logic          fifo_valid,
  input  hrx_pkg::hrx_word_t fifo_word,
  output logic               fifo_ready
);
  import hrx_pkg::*;
  logic [7:0] ch;
  logic       inv;
  int         ones;
  hrx_word_t  got[$];

  initial begin
    rx_in = '0;
    fifo_ready = 1'b0;
    ch = 8'h00;
    inv = 1'b0;
    ones = 0;
  end

  // drain stalls about a quarter of the cycles so the buffer backs up
  always @(posedge clk) begin
    fifo_ready <= rst_n && ($urandom_range(3) != 0);
    if (fifo_valid && fifo_ready)
      got.push_back(fifo_word);
  end

  // bit held until the edge that takes it
  task automatic send_bit(input logic b);
    rx_in <= hrx_bit_t'{valid: 1'b1, data: b ^ inv, chan: ch};
    // ready still shows its pre-edge value here, as the design samples it
    do begin
      @(posedge clk);
    end while (rx_bit_ready !== 1'b1);
  endtask

  // first bit on the line is bit 0 of the octet
  task automatic send_byte(input logic [7:0] v, input logic stuff);
    for (int i = 0; i < 8; i++) begin
      send_bit(v[i]);
      ones = v[i] ? ones + 1 : 0;
      if (stuff && ones == 5) begin
        send_bit(1'b0);
        ones = 0;
      end
    end
  endtask

  task automatic flag();
    send_byte(FLAG_BYTE, 1'b0);
    ones = 0;
  endtask

  // idle line shows the inverse of the last bit, never a stale copy
  task automatic release_line();
    rx_in <= hrx_bit_t'{valid: 1'b0, data: ~rx_in.data, chan: ch};
  endtask
endmodule

// file: tb/tb_hrx_channel.sv
`timescale 1ns/1ps

module tb_hrx_channel;
  import hrx_pkg::*;
  localparam logic [11:0] ADDRS [5] = '{OFS_RX_SEL, OFS_RX_DEF, OFS_MAX_LEN, OFS_TX_SEL, 12'h7FC};
  logic         clk;
  logic         rst_n;
  hrx_bus_req_t bus;
  logic [15:0]  rdata;
  hrx_bit_t     rx_in;
  logic         rx_bit_ready;
  logic         fifo_valid;
  logic         fifo_ready;
  hrx_word_t    fifo_word;
  int           errors;
  int           total_checks;
  logic [15:0]  q;
  logic [7:0]   pl[$];
  hrx_word_t    exp[$];

  hrx_channel dut_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .rx_in(rx_in),
    .rx_bit_ready(rx_bit_ready), .fifo_valid(fifo_valid), .fifo_word(fifo_word),
    .fifo_ready(fifo_ready));
  hrx_src src_u (.clk(clk), .rst_n(rst_n), .rx_in(rx_in), .rx_bit_ready(rx_bit_ready),
    .fifo_valid(fifo_valid), .fifo_word(fifo_word), .fifo_ready(fifo_ready));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // checking and bus helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic op(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= hrx_bus_req_t'{wr: w, rd: !w, addr: a, wdata: d};
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    op(1'b1, a, d);
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [15:0] v);
    op(1'b0, a, 16'h0000);
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask

  task automatic wait_idle(input logic [11:0] a);
    int n = 0;
    do begin
      rd(a, q);
      n++;
    end while (q[SEL_BUSY_BIT] !== 1'b0 && n < 20);
    check("busy clear", {15'h0000, q[SEL_BUSY_BIT]}, 16'h0000);
  endtask

  task automatic cfg(input logic [7:0] c, input logic [15:0] d);
    wr(OFS_RX_DEF, d);
    wr(OFS_RX_SEL, {8'h00, c});
    wait_idle(OFS_RX_SEL);
  endtask

  task automatic frame(input logic [7:0] c, input int tail_ones);
    src_u.ch = c;
    src_u.flag();
    src_u.flag();
    foreach (pl[i]) src_u.send_byte(pl[i], 1'b1);
    repeat (tail_ones) src_u.send_bit(1'b1);
    src_u.flag();
    src_u.flag();
    src_u.release_line();
  endtask

  task automatic expect_words(input string what);
    int n = 0;
    while (src_u.got.size() < exp.size() && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (40) @(posedge clk);
    check({what, " count"}, 16'(src_u.got.size()), 16'(exp.size()));
    foreach (exp[i]) if (i < src_u.got.size()) check(what, 16'(src_u.got[i]), 16'(exp[i]));
    src_u.got.delete();
    exp.delete();
    $display("test %s done", what);
  endtask

  // partial packets end in a word with abort and end flags, data zero
  task automatic expect_marker(input string what);
    repeat (40) @(posedge clk);
    check(what, src_u.got.size() > 0 ? 16'(src_u.got[$]) : 16'hFFFF, 16'h0300);
    src_u.got.delete();
    $display("test %s done", what);
  endtask

  function automatic logic [31:0] fcs(input logic wide);
    logic [31:0] c;
    c = wide ? INIT32 : INIT16;
    foreach (pl[i]) for (int b = 0; b < 8; b++)
      c = (c[0] ^ pl[i][b]) ? (c >> 1) ^ (wide ? POLY32 : POLY16) : c >> 1;
    return ~c;
  endfunction

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0]  c;
    logic [7:0]  b;
    logic [15:0] d;
    logic [15:0] f;
    logic [31:0] g;
    rst_n = 1'b0;
    bus = '0;
    void'($urandom(86023));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ADDRS[i], q);
      check("reset value", q, 16'h0000);
    end
    c = 8'($urandom);
    d = 16'($urandom_range(511));
    wr(OFS_RX_DEF, d);
    op(1'b1, OFS_RX_SEL, {8'h00, c});
    rd(OFS_RX_SEL, q);
    check("busy during write", q, {8'h80, c});
    wait_idle(OFS_RX_SEL);
    wr(OFS_RX_DEF, ~d);
    wr(OFS_RX_SEL, {8'h40, c});
    wait_idle(OFS_RX_SEL);
    check("select readback", q, {8'h40, c});
    rd(OFS_RX_DEF, q);
    check("entry readback", q, d);
    wr(OFS_RX_SEL, {8'h40, c ^ 8'h01});
    wait_idle(OFS_RX_SEL);
    rd(OFS_RX_DEF, q);
    check("neighbour entry", q, 16'h0000);
    f = 16'($urandom);
    wr(OFS_MAX_LEN, f);
    rd(OFS_MAX_LEN, q);
    check("max length", q, f);
    wr(OFS_TX_SEL, 16'hFFFF);
    wait_idle(OFS_TX_SEL);
    check("tx select", q, 16'h40FF);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      cfg(8'h05, 16'h0001 | 16'(m << 4));
      src_u.ch = 8'h05;
      src_u.inv = m[0];
      for (int k = 0; k < 2; k++) begin
        b = 8'($urandom);
        src_u.send_byte(b, 1'b0);
        exp.push_back(hrx_word_t'{1'b0, 1'b0, m[1] ? rev(b) : b});
      end
      src_u.release_line();
      src_u.inv = 1'b0;
      expect_words("transparent");
    end
    cfg(8'h21, 16'h0000);
    pl = {};
    for (int k = 0; k < 5; k++) pl.push_back(8'($urandom));
    pl[1] = 8'hFF;
    foreach (pl[k]) exp.push_back(hrx_word_t'{1'b0, k == 4, pl[k]});
    frame(8'h21, 0);
    expect_words("plain");
    for (int s = 0; s < 2; s++) begin
      cfg(8'h22, 16'h0004 | 16'(s << 6));
      pl = {8'($urandom), 8'($urandom), 8'($urandom)};
      f = 16'(fcs(1'b0));
      foreach (pl[k]) exp.push_back(hrx_word_t'{1'b0, s == 1 && k == 2, pl[k]});
      if (s == 0) begin
        exp.push_back(hrx_word_t'{1'b0, 1'b0, f[7:0]});
        exp.push_back(hrx_word_t'{1'b0, 1'b1, f[15:8]});
      end
      pl.push_back(f[7:0]);
      pl.push_back(f[15:8]);
      frame(8'h22, 0);
      expect_words("crc16");
    end
    pl = {8'h3C};
    f = 16'(fcs(1'b0));
    pl.push_back(f[7:0]);
    pl.push_back(f[15:8]);
    frame(8'h22, 0);
    expect_words("short");
    // 32-bit FCS, stripped: seven octets meet the minimum of six
    cfg(8'h25, 16'h0048);
    pl = {8'($urandom), 8'($urandom), 8'($urandom)};
    foreach (pl[k]) exp.push_back(hrx_word_t'{1'b0, k == 2, pl[k]});
    g = fcs(1'b1);
    for (int k = 0; k < 4; k++) pl.push_back(g[8*k +: 8]);
    frame(8'h25, 0);
    expect_words("crc32");
    wr(OFS_MAX_LEN, 16'h0008);
    cfg(8'h23, 16'h0002);
    pl = {};
    for (int k = 0; k < 12; k++) pl.push_back(8'($urandom));
    frame(8'h23, 0);
    expect_marker("over length");
    cfg(8'h23, 16'h0000);
    foreach (pl[k]) exp.push_back(hrx_word_t'{1'b0, k == 11, pl[k]});
    frame(8'h23, 0);
    expect_words("length off");
    cfg(8'h24, 16'h0000);
    pl = {};
    for (int k = 0; k < 8; k++) pl.push_back(8'($urandom));
    frame(8'h24, 8);
    expect_marker("abort");
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    end_sim();
  end
endmodule
